// >>> rtl/adc_mode_regs.svh
// register offsets, field positions, reset values and counts of the mode-control block
// What this block does
// RQ1 - serial interface active while the enable pin is low; inactive by default
// RQ2 - while active, command pins are ignored and settings come from registers
// RQ3 - while inactive, writes are blocked and registers sit at defaults
// RQ4 - serial data shifts in on each rising edge of the serial clock
// RQ5 - serial bits are taken only while load enable is low
// RQ6 - active-low clear returns all serial registers to defaults
// RQ7 - active-low sync reset is resynchronised to the sampling clock before use
// RQ8 - ratio select high gives 1:2 on ports A and B; low gives 1:1 on A
// RQ9 - in 1:2 both ports update at the same instant
// RQ10 - state bit D0 selects ratio, 0 is 1:1, 1 is 1:2, default 1
// RQ11 - test pin low outputs the 16-word alignment pattern; high gives normal data
// RQ12 - test register 0101 kind: 00 all low, 01 all high, 10 unused, 11 alignment
// RQ13 - in serial mode test output only when active and state bit D2 is 0
// RQ14 - static low and high patterns only through registers; pin gives alignment only
// RQ15 - active-low delay tune enable from pin or register; pin path is fine only
// RQ16 - two-bit coarse delay, registers only, codes select 0, 30, 60, 90 ps
// RQ17 - eight-bit fine delay field spans codes 0 to 255
// RQ18 - ten-bit gain and offset trim fields, codes 0 to 1023
// RQ19 - register-only sync behaviour bit: 1 trigger mode, 0 synchronisation mode
// RQ20 - register-only edge bit: 1 falling edge, 0 rising edge of sync
// RQ21 - register-only rate bit in 1:1: 1 half speed, 0 full speed
// RQ22 - frame is 4 address bits then 12 data bits, both MSB first
// RQ23 - controller keeps load enable high when not writing
// RQ24 - trigger mode in 1:2 passes sync pulse through pipeline to both parity outputs
// RQ25 - when inactive, ratio, test enable and delay enable come straight from pins
`ifndef ADC_MODE_REGS_SVH
`define ADC_MODE_REGS_SVH

`define ADDR_GAIN    4'h1
`define ADDR_OFFSET  4'h2
`define ADDR_DELAY   4'h3
`define ADDR_STATE   4'h4
`define ADDR_TEST    4'h5

`define GAIN_RST     10'h200
`define OFFSET_RST   10'h200
`define FINE_RST     8'h00
`define COARSE_RST   2'h2
`define TEST_RST     2'h3
`define STATE_RST    12'h027

`define ST_RATIO     0
`define ST_DLY_N     1
`define ST_TEST_N    2
`define ST_TRIG      3
`define ST_EDGE      4
`define ST_HSR       5

`define FINE_MSB     7
`define COARSE_LSB   8
`define COARSE_MSB   9
`define TRIM_MSB     9

`define FRAME_LAST   5'h0F
`define TRIG_PIPE    4

`endif

// >>> rtl/adc_mode_pkg.sv
// types shared by the mode-control block
package adc_mode_pkg;
  typedef enum logic [1:0] {
    PAT_ALL_LOW  = 2'h0,
    PAT_ALL_HIGH = 2'h1,
    PAT_UNUSED   = 2'h2,
    PAT_ALIGN    = 2'h3
  } pattern_kind_e;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_SHIFT,
    RX_WAIT
  } rx_state_e;
endpackage

// >>> rtl/cfg_write_if.sv
// register write strobe carried from the serial receiver to the register bank
interface cfg_write_if;
  logic        stb;
  logic [3:0]  addr;
  logic [11:0] data;
  modport source (output stb, output addr, output data);
  modport sink   (input stb, input addr, input data);
endinterface

// >>> rtl/three_wire_rx.sv
// serial frame receiver: samples the write port pins and emits one write per frame
`include "adc_mode_regs.svh"
module three_wire_rx (
  // clock and control
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        clear_i,
  // write port pins, asynchronous
  input  wire logic        ser_clk_i,
  input  wire logic        ser_load_n_i,
  input  wire logic        ser_data_i,
  // decoded write
  cfg_write_if.source      wr
);
  logic [2:0]              sclk_q;
  logic [1:0]              load_q;
  logic [1:0]              data_q;
  logic [15:0]             shift_r;
  logic [4:0]              cnt_r;
  adc_mode_pkg::rx_state_e state_r;
  logic                    rise;
  logic                    stb_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_q <= 3'h0;
      load_q <= 2'h3;
      data_q <= 2'h0;
    end else if (ce_i) begin
      sclk_q <= {sclk_q[1:0], ser_clk_i};
      load_q <= {load_q[0], ser_load_n_i};
      data_q <= {data_q[0], ser_data_i};
    end
  end

  assign rise = sclk_q[1] & ~sclk_q[2]; // RQ4

  // load high ends a frame at once, without waiting for a serial clock edge that may never come,
  // so a cut frame is dropped, never half written or merged with the next one
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && clear_i)) begin
      state_r <= adc_mode_pkg::RX_IDLE;
      cnt_r   <= 5'h0;
      shift_r <= 16'h0;
    end else if (ce_i && load_q[1]) begin
      state_r <= adc_mode_pkg::RX_IDLE; // RQ5
    end else if (ce_i && rise) begin
      case (state_r)
        adc_mode_pkg::RX_IDLE: begin
          shift_r <= {shift_r[14:0], data_q[1]}; // RQ22
          cnt_r   <= 5'h1;
          state_r <= adc_mode_pkg::RX_SHIFT;
        end
        adc_mode_pkg::RX_SHIFT: begin
          shift_r <= {shift_r[14:0], data_q[1]};
          cnt_r   <= cnt_r + 5'h1;
          if (cnt_r == `FRAME_LAST) begin
            state_r <= adc_mode_pkg::RX_WAIT;
          end
        end
        adc_mode_pkg::RX_WAIT: begin
          state_r <= adc_mode_pkg::RX_WAIT;
        end
        default: state_r <= adc_mode_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && clear_i)) begin
      stb_r <= 1'b0;
    end else if (ce_i) begin
      stb_r <= rise && !load_q[1] && (state_r == adc_mode_pkg::RX_SHIFT) && (cnt_r == `FRAME_LAST);
    end
  end

  assign wr.stb  = stb_r;
  assign wr.addr = shift_r[15:12];
  assign wr.data = shift_r[11:0];
endmodule

// >>> rtl/align_pattern_gen.sv
// sixteen-word alignment pattern, starting with four all-zero words
module align_pattern_gen (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        step_i,
  input  wire logic        restart_i,
  output logic [11:0]      word_o,
  output logic             parity_o
);
  logic [3:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && restart_i)) begin
      cnt_r <= 4'h0;
    end else if (ce_i && step_i) begin
      cnt_r <= cnt_r + 4'h1; // RQ11
    end
  end

  // slow bits toggle at rate/4 and rate/8, low nibble carries the fast transitions
  assign word_o   = {{4{cnt_r[3]}}, {4{cnt_r[2]}}, {4{cnt_r[3] & cnt_r[0]}}};
  assign parity_o = cnt_r[3];
endmodule

// >>> rtl/adc_mode_control_select.sv
// mode-control register bank, pin/register selection and output word formatting
`include "adc_mode_regs.svh"
module adc_mode_control_select (
  // clock, reset, enable
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        CLK_EN_I,
  // three-wire write port
  input  wire logic        IF_ENABLE_N_I,
  input  wire logic        SER_CLK_I,
  input  wire logic        SER_LOAD_N_I,
  input  wire logic        SER_DATA_I,
  input  wire logic        SER_CLEAR_N_I,
  // hardware command pins
  input  wire logic        DEMUX_RATIO_SELECT_I,
  input  wire logic        PATTERN_TEST_ENABLE_LOW_I,
  input  wire logic        DELAY_TUNE_ENABLE_LOW_I,
  input  wire logic        SYNC_N_I,
  // conversion words, same clock domain
  input  wire logic        WORD_STB_I,
  input  wire logic [11:0] CONV_A_I,
  input  wire logic [11:0] CONV_B_I,
  // output ports
  output logic [11:0]      PORT_A_O,
  output logic [11:0]      PORT_B_O,
  output logic             PARITY_OUT_PORT_A_O,
  output logic             PARITY_OUT_PORT_B_O,
  output logic             WORD_VALID_O,
  output logic             SYNC_RESET_O,
  // effective settings
  output logic             DEMUX_1TO2_O,
  output logic             HALF_SPEED_O,
  output logic             TRIM_FROM_REG_O,
  output logic [9:0]       GAIN_TRIM_O,
  output logic [9:0]       OFFSET_TRIM_O,
  output logic             FINE_TUNE_EN_O,
  output logic             COARSE_TUNE_EN_O,
  output logic [7:0]       FINE_DELAY_O,
  output logic [1:0]       COARSE_DELAY_O
);
  cfg_write_if wr ();

  logic [1:0]  mode_q;
  logic [1:0]  clr_q;
  logic [1:0]  ratio_q;
  logic [1:0]  tm_q;
  logic [1:0]  dly_q;
  logic [2:0]  sync_q;
  logic        if_active;
  logic        clear;
  logic        hold_default;

  logic [9:0]  gain_trim_r;
  logic [9:0]  offset_trim_r;
  logic [7:0]  fine_r;
  logic [1:0]  coarse_r;
  logic [1:0]  test_kind_r;
  logic [11:0] state_r;

  logic        ratio_eff;
  logic        test_en;
  logic        dly_en;
  adc_mode_pkg::pattern_kind_e kind_eff;
  logic        sync_evt;
  logic        trig_mode;
  logic [`TRIG_PIPE-1:0] trig_pipe_r;
  logic        half_phase_r;
  logic        upd;
  logic [11:0] pat_word;
  logic        pat_par;
  logic [11:0] word_a;
  logic [11:0] word_b;
  logic        par_a;
  logic        par_b;

  // every asynchronous pin passes two flops before use
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      mode_q  <= 2'h3;
      clr_q   <= 2'h3;
      ratio_q <= 2'h3;
      tm_q    <= 2'h3;
      dly_q   <= 2'h3;
      sync_q  <= 3'h7;
    end else if (CLK_EN_I) begin
      mode_q  <= {mode_q[0], IF_ENABLE_N_I};
      clr_q   <= {clr_q[0], SER_CLEAR_N_I};
      ratio_q <= {ratio_q[0], DEMUX_RATIO_SELECT_I};
      tm_q    <= {tm_q[0], PATTERN_TEST_ENABLE_LOW_I};
      dly_q   <= {dly_q[0], DELAY_TUNE_ENABLE_LOW_I};
      sync_q  <= {sync_q[1:0], SYNC_N_I}; // RQ7
    end
  end

  assign if_active    = ~mode_q[1]; // RQ1
  assign clear        = ~clr_q[1];
  assign hold_default = clear || !if_active;

  three_wire_rx u_rx (
    .clk_i        (CORE_CLK_I),
    .rst_i        (RESET_I),
    .ce_i         (CLK_EN_I),
    .clear_i      (clear),
    .ser_clk_i    (SER_CLK_I),
    .ser_load_n_i (SER_LOAD_N_I),
    .ser_data_i   (SER_DATA_I),
    .wr           (wr)
  );

  // clear is sampled on the core clock, so it works with the serial clock stopped
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I || (CLK_EN_I && hold_default)) begin // RQ3 RQ6
      gain_trim_r   <= `GAIN_RST;
      offset_trim_r <= `OFFSET_RST;
      fine_r        <= `FINE_RST;
      coarse_r      <= `COARSE_RST;
      test_kind_r   <= `TEST_RST;
      state_r       <= `STATE_RST;
    end else if (CLK_EN_I && wr.stb) begin
      case (wr.addr)
        `ADDR_GAIN:   gain_trim_r   <= wr.data[`TRIM_MSB:0]; // RQ18
        `ADDR_OFFSET: offset_trim_r <= wr.data[`TRIM_MSB:0]; // RQ18
        `ADDR_DELAY: begin
          fine_r   <= wr.data[`FINE_MSB:0]; // RQ17
          coarse_r <= wr.data[`COARSE_MSB:`COARSE_LSB]; // RQ16
        end
        `ADDR_STATE:  state_r       <= wr.data; // RQ10
        `ADDR_TEST:   test_kind_r   <= wr.data[1:0]; // RQ12
        default:      state_r       <= state_r;
      endcase
    end
  end

  // selection between register bank and command pins
  assign ratio_eff = if_active ? state_r[`ST_RATIO] : ratio_q[1]; // RQ2 RQ25 RQ10
  assign test_en   = if_active ? ~state_r[`ST_TEST_N] : ~tm_q[1]; // RQ13 RQ25 RQ11
  assign dly_en    = if_active ? ~state_r[`ST_DLY_N] : ~dly_q[1]; // RQ15 RQ25
  assign kind_eff  = if_active ? adc_mode_pkg::pattern_kind_e'(test_kind_r)
                               : adc_mode_pkg::PAT_ALIGN; // RQ14
  assign trig_mode = state_r[`ST_TRIG]; // RQ19

  // edge select picks the assertion or the release of the active-low sync
  assign sync_evt = state_r[`ST_EDGE] ? (sync_q[2] & ~sync_q[1])
                                      : (~sync_q[2] & sync_q[1]); // RQ20

  // half speed in 1:1 takes every other word; in 1:2 every word passes
  assign upd = WORD_STB_I && (ratio_eff || !state_r[`ST_HSR] || half_phase_r); // RQ21

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      half_phase_r <= 1'b0;
    end else if (CLK_EN_I && WORD_STB_I) begin
      half_phase_r <= ~half_phase_r;
    end
  end

  align_pattern_gen u_pat (
    .clk_i     (CORE_CLK_I),
    .rst_i     (RESET_I),
    .ce_i      (CLK_EN_I),
    .step_i    (upd),
    .restart_i (sync_evt && !trig_mode),
    .word_o    (pat_word),
    .parity_o  (pat_par)
  );

  // trigger pulse travels through a fixed delay, standing in for the data pipeline
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      trig_pipe_r <= '0;
    end else if (CLK_EN_I) begin
      trig_pipe_r <= {trig_pipe_r[`TRIG_PIPE-2:0], sync_evt && trig_mode}; // RQ24
    end
  end

  always_comb begin
    word_a = CONV_A_I;
    word_b = CONV_B_I;
    par_a  = ^CONV_A_I;
    par_b  = ^CONV_B_I;
    if (test_en) begin // RQ11 RQ13
      case (kind_eff)
        adc_mode_pkg::PAT_ALL_HIGH: begin
          word_a = 12'hFFF;
          par_a  = 1'b1;
        end
        adc_mode_pkg::PAT_ALIGN: begin
          word_a = pat_word;
          par_a  = pat_par;
        end
        default: begin
          word_a = 12'h000;
          par_a  = 1'b0;
        end
      endcase
      word_b = word_a;
      par_b  = par_a;
    end
    if (trig_mode && ratio_eff) begin
      par_a = trig_pipe_r[`TRIG_PIPE-1]; // RQ24
      par_b = trig_pipe_r[`TRIG_PIPE-1];
    end
    if (!ratio_eff) begin
      word_b = 12'h000; // RQ8
      par_b  = 1'b0;
    end
  end

  // both ports load from one enable so they always change together
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      PORT_A_O            <= 12'h000;
      PORT_B_O            <= 12'h000;
      PARITY_OUT_PORT_A_O <= 1'b0;
      PARITY_OUT_PORT_B_O <= 1'b0;
      WORD_VALID_O        <= 1'b0;
    end else if (CLK_EN_I) begin
      WORD_VALID_O <= upd;
      if (upd) begin // RQ8 RQ9
        PORT_A_O <= word_a;
        PORT_B_O <= word_b;
      end
      if (upd || (trig_mode && ratio_eff)) begin
        PARITY_OUT_PORT_A_O <= par_a;
        PARITY_OUT_PORT_B_O <= par_b;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      SYNC_RESET_O     <= 1'b0;
      DEMUX_1TO2_O     <= 1'b1;
      HALF_SPEED_O     <= 1'b1;
      TRIM_FROM_REG_O  <= 1'b0;
      GAIN_TRIM_O      <= `GAIN_RST;
      OFFSET_TRIM_O    <= `OFFSET_RST;
      FINE_TUNE_EN_O   <= 1'b0;
      COARSE_TUNE_EN_O <= 1'b0;
      FINE_DELAY_O     <= `FINE_RST;
      COARSE_DELAY_O   <= `COARSE_RST;
    end else if (CLK_EN_I) begin
      SYNC_RESET_O     <= sync_evt && !trig_mode; // RQ19
      DEMUX_1TO2_O     <= ratio_eff;
      HALF_SPEED_O     <= !ratio_eff && state_r[`ST_HSR]; // RQ21
      TRIM_FROM_REG_O  <= if_active;
      GAIN_TRIM_O      <= gain_trim_r;
      OFFSET_TRIM_O    <= offset_trim_r;
      FINE_TUNE_EN_O   <= dly_en; // RQ15
      COARSE_TUNE_EN_O <= if_active && dly_en; // RQ15 RQ16
      FINE_DELAY_O     <= fine_r;
      COARSE_DELAY_O   <= coarse_r;
    end
  end

  AST_INACTIVE_DEFAULT: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RQ3
    (CLK_EN_I && !if_active) |=> (gain_trim_r == `GAIN_RST) && (state_r == `STATE_RST) && (test_kind_r == `TEST_RST))
    else $error("registers not at default while interface inactive");

  AST_CLEAR_DEFAULT: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RQ6
    (CLK_EN_I && clear) |=> (offset_trim_r == `OFFSET_RST) && (coarse_r == `COARSE_RST) && (fine_r == `FINE_RST))
    else $error("clear did not restore defaults");

  AST_GAIN_WRITE: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RQ18
    (CLK_EN_I && wr.stb && !hold_default && wr.addr == `ADDR_GAIN) |=> gain_trim_r == $past(wr.data[9:0]))
    else $error("gain write not stored");

  AST_PINS_IGNORED: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RQ2
    (CLK_EN_I && if_active && $stable(if_active)) |=> DEMUX_1TO2_O == $past(state_r[`ST_RATIO]))
    else $error("ratio did not follow register while active");

  AST_RATIO_FROM_PIN: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RQ25
    (CLK_EN_I && !if_active) |=> DEMUX_1TO2_O == $past(ratio_q[1]))
    else $error("ratio did not follow pin while inactive");

  AST_PORT_B_QUIET: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RQ8
    (CLK_EN_I && upd && !ratio_eff) |=> (PORT_B_O == 12'h000) && WORD_VALID_O)
    else $error("port B active in 1:1");

  AST_PORTS_TOGETHER: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RQ9
    (CLK_EN_I && upd && ratio_eff && test_en) |=> PORT_A_O == PORT_B_O)
    else $error("ports differ in 1:2 test output");

  AST_PIN_ALIGN_ONLY: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RQ14
    (CLK_EN_I && upd && !if_active && !tm_q[1]) |=> PORT_A_O == $past(pat_word))
    else $error("pin test mode gave a static pattern");

  AST_TRIGGER_PARITY: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RQ24
    (CLK_EN_I && trig_mode && ratio_eff && trig_pipe_r[`TRIG_PIPE-1]) |=> PARITY_OUT_PORT_A_O && PARITY_OUT_PORT_B_O)
    else $error("trigger pulse missing on parity outputs");

  // output-side checks of the pin path, the pattern selection, the sync outputs, the half-speed flag and port B parity
  AST_COARSE_REG_ONLY: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RQ16
    (CLK_EN_I && !if_active)
    |=> !COARSE_TUNE_EN_O)
    else $error("coarse tune enabled from the pin path");

  AST_FINE_FROM_PIN: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RQ15
    (CLK_EN_I && !if_active)
    |=> FINE_TUNE_EN_O == !$past(dly_q[1]))
    else $error("fine tune enable did not follow pin");

  AST_HALF_ONLY_1TO1: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RQ21
    (CLK_EN_I && ratio_eff)
    |=> !HALF_SPEED_O)
    else $error("half speed flagged in 1:2");

  AST_NO_RESET_IN_TRIGGER: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RQ19
    (CLK_EN_I && trig_mode)
    |=> !SYNC_RESET_O)
    else $error("sync reset pulse in trigger mode");

  AST_SYNC_RESET_PULSE: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RQ19 RQ7
    (CLK_EN_I && sync_evt && !trig_mode)
    |=> SYNC_RESET_O)
    else $error("sync event gave no reset pulse");

  AST_STATIC_HIGH: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RQ12
    (CLK_EN_I && upd && test_en && kind_eff == adc_mode_pkg::PAT_ALL_HIGH)
    |=> PORT_A_O == 12'hFFF)
    else $error("all-high pattern not on port A");

  AST_STATIC_LOW: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RQ12
    (CLK_EN_I && upd && test_en && kind_eff == adc_mode_pkg::PAT_ALL_LOW)
    |=> PORT_A_O == 12'h000)
    else $error("all-low pattern not on port A");

  AST_PIN_NORMAL_DATA: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RQ11
    (CLK_EN_I && upd && !if_active && tm_q[1])
    |=> PORT_A_O == $past(CONV_A_I))
    else $error("conversion word lost with test pin high");

  AST_REG_NORMAL_DATA: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RQ13
    (CLK_EN_I && upd && if_active && state_r[`ST_TEST_N])
    |=> PORT_A_O == $past(CONV_A_I))
    else $error("conversion word lost with test bit high");

  AST_INACTIVE_DELAY: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RQ3
    (CLK_EN_I && $past(CLK_EN_I) && !if_active && !$past(if_active))
    |=> COARSE_DELAY_O == `COARSE_RST)
    else $error("coarse delay not at default while interface inactive");

  AST_PORT_B_PARITY_QUIET: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I) // RQ8
    (CLK_EN_I && upd && !ratio_eff)
    |=> !PARITY_OUT_PORT_B_O)
    else $error("port B parity active in 1:1");
endmodule

// >>> tb/serial_ctrl_model.sv
// behavioural controller driving the three-wire write port
module serial_ctrl_model (
  input  wire logic clk_i,
  output logic      sclk_o,
  output logic      load_n_o,
  output logic      data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_o   = 1'b0;
    load_n_o = 1'b1;
    data_o   = 1'b0;
  end
  // four core cycles a half period gives the 320 ns serial clock; it stands still between frames
  // nbits below 16 cuts the frame short by raising load early
  task automatic send(input logic [3:0] addr, input logic [11:0] data, input int nbits = 16);
    logic [15:0] frame;
    frame = {addr, data};
    @(posedge clk_i);
    load_n_o <= 1'b0;
    for (int i = 15; i >= 16 - nbits; i--) begin
      data_o <= frame[i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    load_n_o <= 1'b1;
    // released data line must not keep looking like the last bit
    data_o   <= ~data_o;
    repeat (12) @(posedge clk_i);
  endtask
endmodule

// >>> tb/adc_mode_control_select_bench.sv
// self-checking bench for the mode-control block
`include "adc_mode_regs.svh"
module adc_mode_control_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        if_en_n = 1'b1;
  logic        clear_n = 1'b1;
  logic        ratio = 1'b1;
  logic        tm_n = 1'b1;
  logic        dly_n = 1'b1;
  logic        sync_n = 1'b1;
  logic        stb = 1'b0;
  logic [11:0] conv_a = 12'h000;
  logic [11:0] conv_b = 12'h000;
  logic        sclk, sload_n, sdata;
  logic [11:0] port_a, port_b;
  logic        par_a, par_b, valid, sync_rst, demux, half, trim_reg, fine_en, coarse_en;
  logic [9:0]  gain, offs;
  logic [7:0]  fine;
  logic [1:0]  coarse;
  logic        hit_par;
  logic        hit_rst;
  logic        ce = 1'b1;
  int          bad_count = 0;
  int          tests_run = 0;

  always #20 clk = ~clk;

  serial_ctrl_model ctrl (.clk_i(clk), .sclk_o(sclk), .load_n_o(sload_n), .data_o(sdata));

  adc_mode_control_select DUT (
    .CORE_CLK_I(clk), .RESET_I(rst), .CLK_EN_I(ce),
    .IF_ENABLE_N_I(if_en_n), .SER_CLK_I(sclk), .SER_LOAD_N_I(sload_n), .SER_DATA_I(sdata),
    .SER_CLEAR_N_I(clear_n), .DEMUX_RATIO_SELECT_I(ratio), .PATTERN_TEST_ENABLE_LOW_I(tm_n),
    .DELAY_TUNE_ENABLE_LOW_I(dly_n), .SYNC_N_I(sync_n), .WORD_STB_I(stb), .CONV_A_I(conv_a),
    .CONV_B_I(conv_b), .PORT_A_O(port_a), .PORT_B_O(port_b), .PARITY_OUT_PORT_A_O(par_a),
    .PARITY_OUT_PORT_B_O(par_b), .WORD_VALID_O(valid), .SYNC_RESET_O(sync_rst),
    .DEMUX_1TO2_O(demux), .HALF_SPEED_O(half), .TRIM_FROM_REG_O(trim_reg), .GAIN_TRIM_O(gain),
    .OFFSET_TRIM_O(offs), .FINE_TUNE_EN_O(fine_en), .COARSE_TUNE_EN_O(coarse_en),
    .FINE_DELAY_O(fine), .COARSE_DELAY_O(coarse)
  );

  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic settle();
    repeat (12) @(posedge clk);
    #1;
  endtask

  task automatic word(input logic [11:0] a, input logic [11:0] b);
    @(posedge clk);
    stb    <= 1'b1;
    conv_a <= a;
    conv_b <= b;
    @(posedge clk);
    stb <= 1'b0;
    #1;
  endtask

  // watch a pulse for a bounded span after a sync edge
  task automatic sync_edge(input logic lvl);
    @(posedge clk);
    sync_n <= lvl;
    hit_par = 1'b0;
    hit_rst = 1'b0;
    repeat (14) begin
      @(posedge clk);
      #1;
      if (par_a === 1'b1 && par_b === 1'b1) hit_par = 1'b1;
      if (sync_rst === 1'b1) hit_rst = 1'b1;
    end
  endtask

  task automatic t_pins();
    @(posedge clk);
    ratio <= 1'b0;
    dly_n <= 1'b0;
    settle();
    chk("ratio_pin", {11'h0, demux}, 12'h000);
    chk("fine_en", {11'h0, fine_en}, 12'h001);
    chk("coarse_en", {11'h0, coarse_en}, 12'h000);
    chk("trim_src", {11'h0, trim_reg}, 12'h000);
    chk("half_dflt", {11'h0, half}, 12'h001);
    ctrl.send(`ADDR_GAIN, 12'h155);
    chk("gain_blocked", {2'h0, gain}, 12'h200);
    @(posedge clk);
    ratio <= 1'b1;
    settle();
    word(12'h123, 12'h456);
    chk("port_a", port_a, 12'h123);
    chk("port_b", port_b, 12'h456);
    chk("valid", {11'h0, valid}, 12'h001);
    chk("parity", {11'h0, par_a}, {11'h0, ^12'h123});
    @(posedge clk);
    ce <= 1'b0;
    word(12'h789, 12'hABC);
    chk("frozen_a", port_a, 12'h123);
    @(posedge clk);
    ce <= 1'b1;
  endtask

  task automatic t_pin_pattern();
    logic [11:0] acc;
    acc = 12'h000;
    @(posedge clk);
    tm_n   <= 1'b0;
    sync_n <= 1'b0;
    settle();
    sync_edge(1'b1);
    chk("sync_pulse", {11'h0, hit_rst}, 12'h001);
    // four zero words open each 16-word period, so words 16 to 19 repeat them
    for (int k = 0; k < 20; k++) begin
      word(12'hABC, 12'h555);
      if (k < 4 || k > 15) begin
        chk("align_a", port_a, 12'h000);
        chk("align_b", port_b, 12'h000);
      end else begin
        acc = acc | port_a;
      end
    end
    chk("align_moves", {11'h0, |acc}, 12'h001);
    @(posedge clk);
    tm_n <= 1'b1;
  endtask

  task automatic t_regs();
    @(posedge clk);
    if_en_n <= 1'b0;
    ratio   <= 1'b0;
    settle();
    chk("trim_src", {11'h0, trim_reg}, 12'h001);
    chk("ratio_dflt", {11'h0, demux}, 12'h001);
    ctrl.send(`ADDR_GAIN, 12'h3FF);
    ctrl.send(`ADDR_GAIN, 12'h000, 10);
    ctrl.send(`ADDR_OFFSET, 12'h000);
    chk("gain", {2'h0, gain}, 12'h3FF);
    chk("offset", {2'h0, offs}, 12'h000);
    for (int c = 0; c < 4; c++) begin
      ctrl.send(`ADDR_DELAY, {2'h0, 2'(c), 8'hA5});
      chk("coarse", {10'h0, coarse}, 12'(c));
      chk("fine", {4'h0, fine}, 12'h0A5);
    end
    ctrl.send(`ADDR_STATE, 12'h004);
    chk("ratio_reg", {11'h0, demux}, 12'h000);
    chk("half_off", {11'h0, half}, 12'h000);
    chk("coarse_en", {11'h0, coarse_en}, 12'h001);
    word(12'h321, 12'h654);
    chk("port_a_1to1", port_a, 12'h321);
    chk("port_b_1to1", port_b, 12'h000);
  endtask

  task automatic t_test();
    ctrl.send(`ADDR_STATE, 12'h003);
    for (int k = 0; k < 3; k++) begin
      ctrl.send(`ADDR_TEST, 12'(k));
      word(12'hABC, 12'h555);
      chk("static_a", port_a, (k == 1) ? 12'hFFF : 12'h000);
      chk("static_b", port_b, (k == 1) ? 12'hFFF : 12'h000);
    end
  endtask

  task automatic t_sync();
    ctrl.send(`ADDR_STATE, 12'h01F);
    sync_edge(1'b0);
    chk("trigger", {11'h0, hit_par}, 12'h001);
    chk("trig_no_reset", {11'h0, hit_rst}, 12'h000);
    sync_edge(1'b1);
    chk("rise_ignored", {11'h0, hit_par}, 12'h000);
    ctrl.send(`ADDR_STATE, 12'h017);
    sync_edge(1'b0);
    chk("sync_fall", {11'h0, hit_rst}, 12'h001);
    chk("sync_no_trig", {11'h0, hit_par}, 12'h000);
    @(posedge clk);
    sync_n <= 1'b1;
  endtask

  task automatic t_clear();
    ctrl.send(`ADDR_GAIN, 12'h0AA);
    chk("gain_set", {2'h0, gain}, 12'h0AA);
    @(posedge clk);
    clear_n <= 1'b0;
    repeat (6) @(posedge clk);
    clear_n <= 1'b1;
    settle();
    chk("gain_clear", {2'h0, gain}, 12'h200);
    ctrl.send(`ADDR_GAIN, 12'h0AA);
    chk("gain_reopen", {2'h0, gain}, 12'h0AA);
    @(posedge clk);
    if_en_n <= 1'b1;
    settle();
    chk("gain_inactive", {2'h0, gain}, 12'h200);
    chk("trim_src_off", {11'h0, trim_reg}, 12'h000);
  endtask

  task automatic stop_test();
    if (bad_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    settle();
    t_pins();
    t_pin_pattern();
    t_regs();
    t_test();
    t_sync();
    t_clear();
    stop_test();
  end
endmodule
